/* core/dhp_burst_timer.sv */
// tone burst and pause sequencer
// assumes one clock; start restarts a burst, abort returns to idle
`include "dhp_defs.svh"

module dhp_burst_timer #(
    parameter int MS_CYCLES = `DHP_MS_CYCLES,
    parameter int BURST_MS = `DHP_BURST_MS
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    input wire logic extended,
    input wire logic abort,
    output logic burst_active,
    output logic done
);
    import dhp_pkg::*;

    localparam int DW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

    dhp_burst_state_t state;
    logic [DW-1:0] divider;
    logic [7:0] ms_count;
    logic [7:0] ms_limit;
    logic ms_tick;

    // extended mode doubles both the burst and the pause
    assign ms_limit = extended ? 8'(2 * BURST_MS) : 8'(BURST_MS);
    assign ms_tick = (divider == DW'(MS_CYCLES - 1));
    assign burst_active = (state == DHP_BURST);

    // -----------------------------------------------------------
    // millisecond divider
    // -----------------------------------------------------------
    // restarted with each burst so the first ms is a full one
    always_ff @(posedge clock) begin
        if (!reset_n || start || ms_tick) begin
            divider <= '0;
        end else begin
            divider <= divider + DW'(1);
        end
    end

    // -----------------------------------------------------------
    // burst and pause sequence
    // -----------------------------------------------------------
    always_ff @(posedge clock) begin
        done <= 1'b0;
        if (!reset_n || abort) begin
            state <= DHP_IDLE;
            ms_count <= 8'h00;
        end else if (start) begin
            state <= DHP_BURST;
            ms_count <= 8'h00;
        end else if (ms_tick && state != DHP_IDLE) begin
            if (ms_count == ms_limit - 8'h01) begin
                ms_count <= 8'h00;
                case (state)
                    DHP_BURST: begin
                        state <= DHP_PAUSE;
                    end
                    DHP_PAUSE: begin
                        state <= DHP_IDLE;
                        done <= 1'b1;
                    end
                    default: begin
                        state <= DHP_IDLE;
                    end
                endcase
            end else begin
                ms_count <= ms_count + 8'h01;
            end
        end
    end

endmodule

/* core/dhp_host_port.sv */
// host register port of a tone transceiver
// assumes the receive side gives same-clock digit and steering signals,
// host pins and the call progress square wave are asynchronous
`include "dhp_defs.svh"

module dhp_host_port #(
    parameter int MS_CYCLES = `DHP_MS_CYCLES,
    parameter int BURST_MS = `DHP_BURST_MS
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic register_select_line,
    input wire logic [3:0] data_in,
    output logic [3:0] data_out,
    output logic data_oe_n,
    input wire logic digit_valid,
    input wire logic [3:0] digit_code,
    input wire logic tone_validated,
    input wire logic cp_square_in,
    output logic digit_detect_enable,
    output dhp_pkg::dhp_tone_cmd_t tone_cmd,
    output logic event_or_tone_out_pin,
    output logic event_or_tone_oe_n
);
    import dhp_pkg::*;

    // -----------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------
    dhp_pins_t pins_raw;
    dhp_pins_t sync1;
    dhp_pins_t sync2;
    dhp_pins_t sync3;
    dhp_pins_t pins;

    assign pins_raw = {cp_square_in, chip_select_n, read_n, write_n,
                       register_select_line, data_in};

    // three stages; pins settle only when stages two and three agree
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync1 <= '1;
            sync2 <= '1;
            sync3 <= '1;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // bitwise hold on disagreement filters one-cycle glitches
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pins <= '1;
        end else begin
            pins <= (sync2 & sync3) | (pins & (sync2 ^ sync3));
        end
    end

    // -----------------------------------------------------------
    // access tracking
    // -----------------------------------------------------------
    logic read_active;
    logic write_active;
    logic access_sel;
    logic [3:0] write_data;
    logic read_start;
    logic read_end;
    logic write_end;
    logic read_now;
    logic write_now;

    assign read_now = !pins.cs_n && !pins.rd_n && pins.wr_n;
    assign write_now = !pins.cs_n && !pins.wr_n && pins.rd_n;
    assign read_start = read_now && !read_active;
    assign read_end = read_active && !read_now;
    assign write_end = write_active && pins.wr_n;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            read_active <= 1'b0;
        end else begin
            read_active <= read_now;
        end
    end

    // write stays armed until the strobe ends even if select rises
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            write_active <= 1'b0;
        end else if (write_now) begin
            write_active <= 1'b1;
        end else if (pins.wr_n) begin
            write_active <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            write_data <= 4'h0;
            access_sel <= `DHP_SEL_DATA;
        end else if (write_now) begin
            write_data <= pins.data;
            access_sel <= pins.rs;
        end else if (read_start) begin
            access_sel <= pins.rs;
        end
    end

    // -----------------------------------------------------------
    // registers written by the host
    // -----------------------------------------------------------
    logic [3:0] transmit_digit;
    dhp_ctrl_a_t control_first;
    dhp_ctrl_b_t control_second;
    logic second_control_pointer;
    logic tx_write;
    logic ctrl_write;

    assign tx_write = write_end && access_sel == `DHP_SEL_DATA;
    assign ctrl_write = write_end && access_sel == `DHP_SEL_CTRL;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            transmit_digit <= `DHP_DIGIT_RESET;
        end else if (tx_write) begin
            transmit_digit <= write_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            control_first <= `DHP_CTRL_RESET;
            control_second <= `DHP_CTRL_RESET;
            second_control_pointer <= 1'b0;
        end else if (ctrl_write) begin
            if (second_control_pointer) begin
                control_second <= write_data;
                second_control_pointer <= 1'b0;
            end else begin
                control_first <= write_data;
                second_control_pointer <= write_data[`DHP_A_PTR];
            end
        end
    end

    // -----------------------------------------------------------
    // burst timing
    // -----------------------------------------------------------
    logic burst_mode;
    logic burst_active;
    logic burst_done;

    assign burst_mode = !control_second.burst_off;

    dhp_burst_timer #(
        .MS_CYCLES(MS_CYCLES),
        .BURST_MS(BURST_MS)
    ) u_burst (
        .clock(clock),
        .reset_n(reset_n),
        .start(tx_write && burst_mode),
        .extended(control_first.call_progress),
        .abort(!burst_mode),
        .burst_active(burst_active),
        .done(burst_done)
    );

    // -----------------------------------------------------------
    // tone generator command
    // -----------------------------------------------------------
    // tone gated by enable bit
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            tone_cmd <= '0;
        end else begin
            tone_cmd.on <= control_first.tone_enable &&
                           (!burst_mode || burst_active);
            tone_cmd.single <= control_second.single;
            tone_cmd.column <= control_second.column;
            tone_cmd.code <= transmit_digit;
        end
    end

    // -----------------------------------------------------------
    // receive side
    // -----------------------------------------------------------
    logic [3:0] received_digit;
    logic digit_taken;

    assign digit_detect_enable = !control_first.call_progress;
    assign digit_taken = digit_valid && digit_detect_enable;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            received_digit <= `DHP_DIGIT_RESET;
        end else if (digit_taken) begin
            received_digit <= digit_code;
        end
    end

    // -----------------------------------------------------------
    // status flags
    // -----------------------------------------------------------
    dhp_status_t transceiver_state;
    logic status_read_end;

    // clear only once the read finishes
    assign status_read_end = read_end && access_sel == `DHP_SEL_CTRL;

    // set wins over a clear in the same cycle so an event in the clearing cycle is kept
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            transceiver_state <= '0;
        end else begin
            if (burst_done && burst_mode) begin
                transceiver_state.tx_empty <= 1'b1;
            end else if (status_read_end || !burst_mode) begin
                transceiver_state.tx_empty <= 1'b0;
            end
            if (digit_taken) begin
                transceiver_state.rx_full <= 1'b1;
            end else if (status_read_end) begin
                transceiver_state.rx_full <= 1'b0;
            end
            if ((burst_done && burst_mode) || digit_taken) begin
                transceiver_state.irq <= 1'b1;
            end else if (status_read_end) begin
                transceiver_state.irq <= 1'b0;
            end
            transceiver_state.steering <= !tone_validated;
        end
    end

    // -----------------------------------------------------------
    // read data
    // -----------------------------------------------------------
    // snapshot at read start
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            data_out <= 4'h0;
        end else if (read_start) begin
            if (pins.rs == `DHP_SEL_DATA) begin
                data_out <= received_digit;
            end else begin
                data_out <= transceiver_state;
            end
        end
    end

    // drive only while the strobe is held and data has settled
    assign data_oe_n = !(read_active && read_now);

    // -----------------------------------------------------------
    // shared interrupt or tone pin
    // -----------------------------------------------------------
    logic pull_low;

    // open drain: only ever pulls low, pull-up makes the high level
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pull_low <= 1'b0;
        end else if (control_first.call_progress) begin
            pull_low <= control_first.irq_enable && !pins.cp_square;
        end else if (control_second.test) begin
            pull_low <= !transceiver_state.steering;
        end else begin
            pull_low <= control_first.irq_enable &&
                        transceiver_state.irq;
        end
    end

    assign event_or_tone_out_pin = 1'b0;
    assign event_or_tone_oe_n = !pull_low;

endmodule

/* include/dhp_defs.svh */
// constants for the tone transceiver host register port
// assumes a 10 MHz core clock and a 4-bit multiplexed host bus
`ifndef DHP_DEFS_SVH
`define DHP_DEFS_SVH

// register select line values
`define DHP_SEL_DATA 1'b0
`define DHP_SEL_CTRL 1'b1

// first control register bit positions
`define DHP_A_TONE 0
`define DHP_A_MODE 1
`define DHP_A_IRQ 2
`define DHP_A_PTR 3

// second control register bit positions
`define DHP_B_BURST_OFF 0
`define DHP_B_TEST 1
`define DHP_B_SINGLE 2
`define DHP_B_COLUMN 3

// status bit positions
`define DHP_S_IRQ 0
`define DHP_S_TX_EMPTY 1
`define DHP_S_RX_FULL 2
`define DHP_S_STEER 3

// reset values
`define DHP_CTRL_RESET 4'h0
`define DHP_DIGIT_RESET 4'h0

// timing: clock rate, burst length in ms, ms tick in cycles
`define DHP_CLOCK_HZ 10000000
`define DHP_BURST_MS 51
`define DHP_MS_CYCLES (`DHP_CLOCK_HZ / 1000)

`endif

/* include/dhp_pkg.sv */
// types shared by the tone transceiver host register port
// assumes dhp_defs.svh for the numeric constants
package dhp_pkg;

    typedef struct packed {
        logic select_second;
        logic irq_enable;
        logic call_progress;
        logic tone_enable;
    } dhp_ctrl_a_t;

    typedef struct packed {
        logic column;
        logic single;
        logic test;
        logic burst_off;
    } dhp_ctrl_b_t;

    typedef struct packed {
        logic steering;
        logic rx_full;
        logic tx_empty;
        logic irq;
    } dhp_status_t;

    // command to the tone generator
    typedef struct packed {
        logic on;
        logic single;
        logic column;
        logic [3:0] code;
    } dhp_tone_cmd_t;

    // host pins after synchronisation
    typedef struct packed {
        logic cp_square;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic rs;
        logic [3:0] data;
    } dhp_pins_t;

    typedef enum logic [1:0] {
        DHP_IDLE,
        DHP_BURST,
        DHP_PAUSE
    } dhp_burst_state_t;

endpackage

/* tb/dhp_host_model.sv */
// host bus master model for the tone transceiver register port
// assumes the port filters its strobes; access length is fixed
module dhp_host_model (
    input wire logic clock,
    input wire logic [3:0] data_out,
    input wire logic data_oe_n,
    output logic chip_select_n,
    output logic read_n,
    output logic write_n,
    output logic register_select_line,
    output logic [3:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        chip_select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        register_select_line = 1'b0;
        data_in = 4'h5;
    end
    // select held low around one strobe only
    // fixed strobe length, no wait states
    task automatic wr(input logic rs, input logic [3:0] d);
        @(posedge clock);
        #1;
        chip_select_n = 1'b0;
        register_select_line = rs;
        data_in = d;
        write_n = 1'b0;
        repeat (10) @(posedge clock);
        #1;
        write_n = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        chip_select_n = 1'b1;
        data_in = ~d; // released bus must not keep the old value
        repeat (4) @(posedge clock);
        // hand back off the edge so the caller drives clear of sampling
        #1;
    endtask
    task automatic rd(input logic rs, output logic [3:0] d);
        @(posedge clock);
        #1;
        chip_select_n = 1'b0;
        register_select_line = rs;
        read_n = 1'b0;
        repeat (10) @(posedge clock);
        d = (data_oe_n === 1'b0) ? data_out : 4'hx;
        #1;
        read_n = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        chip_select_n = 1'b1;
        repeat (4) @(posedge clock);
        #1;
    endtask
endmodule

/* tb/dhp_host_port_props.sv */
// checker for the host register port, sees only its ports
// assumes strobes pass a synchroniser of about four cycles
module dhp_host_port_props
    import dhp_pkg::*;
#(
    parameter int MS_CYCLES = 10000,
    parameter int BURST_MS = 51
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic register_select_line,
    input wire logic [3:0] data_in,
    input wire logic [3:0] data_out,
    input wire logic data_oe_n,
    input wire logic digit_valid,
    input wire logic [3:0] digit_code,
    input wire logic tone_validated,
    input wire logic cp_square_in,
    input wire logic digit_detect_enable,
    input wire dhp_tone_cmd_t tone_cmd,
    input wire logic event_or_tone_out_pin,
    input wire logic event_or_tone_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic [4:0] since_wr;
    // cycles since the write strobe rose; settings may only move after it
    always_ff @(posedge clock) begin
        if (!reset_n || !write_n) begin
            since_wr <= 5'h00;
        end else if (since_wr != 5'h1f) begin
            since_wr <= since_wr + 5'h01;
        end
    end
    chk_cs_blocks_drive: assert property (
        chip_select_n [*8] |-> data_oe_n)
        else $error("data bus driven without chip select");
    chk_write_no_drive: assert property (
        (!write_n && read_n) [*8] |-> data_oe_n)
        else $error("data bus driven during a write");
    chk_read_answers: assert property (
        (!read_n && !chip_select_n && write_n) [*8] |-> !data_oe_n)
        else $error("read not answered in time");
    chk_read_release: assert property (
        read_n [*8] |-> data_oe_n)
        else $error("data bus held after read");
    chk_driven_steady: assert property (
        !data_oe_n && !$past(data_oe_n) |-> $stable(data_out))
        else $error("read data moved while driven");
    chk_mode_by_write: assert property (
        $changed(digit_detect_enable) |-> since_wr < 5'd12)
        else $error("receive mode changed without a write");
    chk_code_by_write: assert property (
        $changed(tone_cmd.code) |-> since_wr < 5'd12)
        else $error("tone code changed without a write");
    chk_tone_sel_write: assert property (
        $changed(tone_cmd.single) || $changed(tone_cmd.column)
        |-> since_wr < 5'd12)
        else $error("tone selection changed without a write");
    chk_cp_released: assert property (
        (!digit_detect_enable && cp_square_in) [*6]
        |-> event_or_tone_oe_n)
        else $error("pin low while call progress tone high");
    chk_pin_open_drain: assert property (
        event_or_tone_out_pin == 1'b0)
        else $error("pin drives high");
    cov_read: cover property (!data_oe_n);
    cov_cp_low: cover property (!digit_detect_enable && !event_or_tone_oe_n);
    cov_tone_on: cover property (tone_cmd.on);
endmodule
bind dhp_host_port dhp_host_port_props #(
    .MS_CYCLES(MS_CYCLES),
    .BURST_MS(BURST_MS)
) i_dhp_host_port_props (
    .clock(clock),
    .reset_n(reset_n),
    .chip_select_n(chip_select_n),
    .read_n(read_n),
    .write_n(write_n),
    .register_select_line(register_select_line),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .digit_valid(digit_valid),
    .digit_code(digit_code),
    .tone_validated(tone_validated),
    .cp_square_in(cp_square_in),
    .digit_detect_enable(digit_detect_enable),
    .tone_cmd(tone_cmd),
    .event_or_tone_out_pin(event_or_tone_out_pin),
    .event_or_tone_oe_n(event_or_tone_oe_n)
);

/* tb/dhp_host_port_tb_top.sv */
// testbench for the host register port with a host bus model
// assumes short burst timing parameters to keep the run brief
module dhp_host_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dhp_pkg::*;
    localparam int BURST = 30; // 10 cycles a ms, 3 ms
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic cs_n, rd_n, wr_n, rs, oe_n, dv, tv, cps, dde, pin, pin_oe_n;
    logic [3:0] din, dout, dcode, code;
    dhp_tone_cmd_t tone_cmd;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int on_cycles = 0;
    initial begin
        dv = 1'b0;
        tv = 1'b0;
        cps = 1'b1;
        dcode = 4'h0;
    end
    initial forever #50 clock = ~clock;
    dhp_host_model i_dhp_host_model (.clock(clock), .data_out(dout),
        .data_oe_n(oe_n), .chip_select_n(cs_n), .read_n(rd_n),
        .write_n(wr_n), .register_select_line(rs), .data_in(din));
    dhp_host_port #(.MS_CYCLES(10), .BURST_MS(3)) i_dhp_host_port (
        .clock(clock), .reset_n(reset_n), .chip_select_n(cs_n),
        .read_n(rd_n), .write_n(wr_n), .register_select_line(rs),
        .data_in(din), .data_out(dout), .data_oe_n(oe_n),
        .digit_valid(dv), .digit_code(dcode), .tone_validated(tv),
        .cp_square_in(cps), .digit_detect_enable(dde),
        .tone_cmd(tone_cmd), .event_or_tone_out_pin(pin),
        .event_or_tone_oe_n(pin_oe_n));
    // hang guard and burst length monitor
    always @(posedge clock) begin
        cycles++;
        if (tone_cmd.on === 1'b1) on_cycles++;
        if (cycles == 12000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [3:0] st(logic irq, logic txe, logic rxf);
        return {~tv, rxf, txe, irq}; // steering is the inverse of tone
    endfunction
    task automatic w(logic s, logic [3:0] d);
        i_dhp_host_model.wr(s, d);
    endtask
    task automatic r(logic s, logic [3:0] exp, string what);
        logic [3:0] v;
        i_dhp_host_model.rd(s, v);
        chk(what, 8'(exp), 8'(v));
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    initial begin
        void'($urandom(92));
        tick(16);
        reset_n = 1'b1;
        r(1'b1, st(1'b0, 1'b0, 1'b0), "status at start");
        w(1'b1, 4'h0);
        w(1'b1, 4'h0);
        w(1'b1, 4'h8);
        w(1'b1, 4'h0);
        r(1'b1, st(1'b0, 1'b0, 1'b0), "status after init");
        $display("test init done");
        // receive digits, corner codes then random
        w(1'b1, 4'h4);
        for (int i = 0; i < 5; i++) begin
            code = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
            tv = 1'($urandom);
            dcode = code;
            dv = 1'b1;
            tick(1);
            dv = 1'b0;
            tick(3);
            chk("irq pin on digit", 8'h00, 8'(pin_oe_n));
            r(1'b1, st(1'b1, 1'b0, 1'b1), "status full");
            tick(2);
            chk("irq pin after read", 8'h01, 8'(pin_oe_n));
            r(1'b0, code, "received digit");
            r(1'b1, st(1'b0, 1'b0, 1'b0), "status cleared");
        end
        $display("test receive done");
        // tone selection through the shared control address
        for (int i = 0; i < 4; i++) begin
            logic [3:0] b;
            logic [7:0] exp8;
            b = {i[1], i[0], 2'b01};
            code = 4'($urandom);
            w(1'b1, 4'h9);
            w(1'b1, b);
            w(1'b0, code);
            exp8 = {2'b01, b[2], b[3], code};
            chk("tone command", exp8, 8'(tone_cmd));
        end
        w(1'b1, 4'h1);
        chk("pointer back to first", 8'h01, 8'(tone_cmd.on));
        w(1'b1, 4'h0);
        chk("tone off", 8'h00, 8'(tone_cmd.on));
        $display("test tone select done");
        // burst then pause, dtmf then doubled in call progress
        w(1'b1, 4'h9);
        w(1'b1, 4'h0);
        for (int m = 0; m < 2; m++) begin
            int n;
            w(1'b1, m ? 4'h3 : 4'h5);
            on_cycles = 0;
            w(1'b0, 4'($urandom));
            n = 0;
            while ((tone_cmd.on !== 1'b0 || on_cycles == 0) && n < 400) begin
                @(posedge clock);
                n++;
            end
            #1;
            chk("burst cycles", 8'((m + 1) * BURST), 8'(on_cycles));
            tick((m + 1) * BURST - 3);
            if (m == 0) chk("no early ready", 8'h01, 8'(pin_oe_n));
            tick(13);
            if (m == 0) chk("ready irq", 8'h00, 8'(pin_oe_n));
            r(1'b1, st(1'b1, 1'b1, 1'b0), "status ready");
            r(1'b1, st(1'b0, 1'b0, 1'b0), "status ready clr");
        end
        $display("test burst done");
        // call progress copy on the pin, digits ignored
        w(1'b1, 4'h6);
        chk("detect off", 8'h00, 8'(dde));
        for (int i = 0; i < 3; i++) begin
            cps = 1'b0;
            tick(8);
            chk("pin copies low", 8'h00, 8'(pin_oe_n));
            cps = 1'b1;
            tick(8);
            chk("pin copies high", 8'h01, 8'(pin_oe_n));
        end
        dv = 1'b1;
        tick(1);
        dv = 1'b0;
        r(1'b1, st(1'b0, 1'b0, 1'b0), "digit in cp");
        $display("test call progress done");
        // test mode: pin follows the validated tone flag
        w(1'b1, 4'h8);
        w(1'b1, 4'h3);
        w(1'b1, 4'h0);
        tv = 1'b1;
        tick(8);
        chk("test pin low", 8'h00, 8'(pin_oe_n));
        tv = 1'b0;
        tick(8);
        chk("test pin high", 8'h01, 8'(pin_oe_n));
        $display("test test mode done");
        wrap_up();
    end
endmodule
